// [hdl/aoscr_consts.svh]
/*
 * Offsets, field positions, reset values and widths of the output stream
 * configuration bank. Assumes nothing beyond a SystemVerilog compiler.
 */
`ifndef AOSCR_CONSTS_SVH
`define AOSCR_CONSTS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define AOSCR_IDX_PATT_LO   6'h1B
`define AOSCR_IDX_PATT_HI   6'h1C
`define AOSCR_IDX_STREAM    6'h21
`define AOSCR_IDX_LANE      6'h22
`define AOSCR_IDX_LANE_SEL  6'h30
`define AOSCR_IDX_ROUTE     6'h31

// ****************************************************************
// Field positions
// ****************************************************************
`define AOSCR_LSB_FIRST_BIT 7
`define AOSCR_LOW_RATE_BIT  3
`define AOSCR_RES_HI        2
`define AOSCR_RES_LO        0
`define AOSCR_CH_RST_BIT    1
`define AOSCR_CH_PD_BIT     0
`define AOSCR_ROUTE_BIT     0

// ****************************************************************
// Reset values and sizes
// ****************************************************************
`define AOSCR_RST_BYTE      8'h00
`define AOSCR_RST_LANE_SEL  4'hF
`define AOSCR_NCH           4
`define AOSCR_WORD_W        14
`define AOSCR_NBITS_NATIVE  4'hA
`define AOSCR_NBITS_12      4'hC
`define AOSCR_NBITS_14      4'hE

`endif

// [hdl/aoscr_pkg.sv]
/*
 * Types shared by the output stream configuration bank.
 * Assumes the constants header is compiled alongside.
 */
package aoscr_pkg;
    // Output resolution codes that differ from the native width
    typedef enum logic [2:0] {
        AOSCR_RES_12 = 3'h3,
        AOSCR_RES_14 = 3'h4
    } aoscr_res_type;
endpackage

// [hdl/aoscr_lane_if.sv]
/*
 * Link between the register bank and one lane serializer.
 * Assumes both ends run on the same pclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface aoscr_lane_if;
    logic        load;       // Start of a new word next cycle
    logic [13:0] word;       // Word to send, right aligned
    logic [3:0]  nbits;      // Serial word length
    logic        lsb_first;  // Bit order
    logic        hold;       // Lane quiet: reset or powered down
    logic        dout;       // Serial data, registered
    modport ctl  (output load, word, nbits, lsb_first, hold, input dout);
    modport lane (input load, word, nbits, lsb_first, hold, output dout);
endinterface
`default_nettype wire

// [hdl/aoscr_lane.sv]
/*
 * One lane serializer: shifts a word out one bit per clock.
 * Assumes load comes from the shared frame counter.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aoscr_consts.svh"
module aoscr_lane
    import aoscr_pkg::*;
(
    input wire logic     pclk,
    input wire logic     presetn,
    aoscr_lane_if.lane   lnk
);
    logic [13:0] shreg;       // Bits still to send
    logic [13:0] next_shreg;
    logic        dout_q;      // Registered serial bit
    logic        next_dout;

    // ****************************************************************
    // Next shift state
    // ****************************************************************
    always_comb begin
        next_shreg = lnk.lsb_first ? (shreg >> 1) : (shreg << 1);
        if (lnk.load) begin
            // MSB first: left align so bit 13 leaves first
            if (lnk.lsb_first) begin
                next_shreg = lnk.word;
            end else begin
                next_shreg = lnk.word << (5'(`AOSCR_WORD_W) - {1'b0, lnk.nbits});
            end
        end
        // Quiet lane sits low rather than sending stale words
        next_dout = lnk.hold ? 1'b0
                  : (lnk.lsb_first ? next_shreg[0] : next_shreg[13]);
    end

    // Registers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg  <= 14'h0000;
            dout_q <= 1'b0;
        end else begin
            shreg  <= next_shreg;
            dout_q <= next_dout;
        end
    end

    assign lnk.dout = dout_q;
endmodule
`default_nettype wire

// [hdl/aoscr_frame.sv]
/*
 * Shared bit counter: marks word boundaries for all lanes.
 * Assumes nbits is at least two.
 */
`timescale 1ns/1ps
`default_nettype none
module aoscr_frame (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] nbits,
    output logic            load,
    output logic            frame
);
    logic [3:0] cnt;        // Bit position within the word
    logic [3:0] next_cnt;
    logic       next_frame;

    // ****************************************************************
    // Counter next state
    // ****************************************************************
    always_comb begin
        // Greater-or-equal so a shortened word length cannot strand it
        load       = (cnt >= (nbits - 4'h1));
        next_cnt   = load ? 4'h0 : cnt + 4'h1;
        next_frame = load;
    end

    // Registers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt   <= 4'h0;
            frame <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            frame <= next_frame;
        end
    end
endmodule
`default_nettype wire

// [hdl/aoscr_top.sv]
/*
 * Output stream configuration bank of a quad converter: second user
 * pattern, serial stream format and per-lane reset and power-down,
 * reached over APB, driving four lane serializers.
 * Assumes converter words arrive on pclk; zero-wait APB slave.
 */
// The APB register port was decided locally.
// How it works
// [R1] Pattern two low byte, reset zero
// [R2] Pattern two high byte, reset zero
// [R3] LSB-first bit sends low bit first
// [R4] Default: MSB first, native width, all lanes
// [R5] Low encode rate mode bit, default off
// [R6] Code 011 twelve bits, 100 fourteen
// [R7] Lane output reset holds addressed lane
// [R8] Lane power-down powers addressed lane down
// [R9] Lane register acts only on selected lanes
// [R10] Quiet lane drives static low data
`timescale 1ns/1ps
`default_nettype none
`include "aoscr_consts.svh"
module aoscr_top
    import aoscr_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [3:0][13:0] sample_word,
    output logic [3:0]            serial_data,
    output logic                  frame_out,
    output logic                  low_rate_mode,
    output logic [3:0]            lane_power_down,
    output logic [3:0]            lane_out_reset
);
    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [7:0]  patt_lo;         // Pattern two, bits 7..0
    logic [7:0]  patt_hi;         // Pattern two, bits 15..8
    logic        lsb_first;       // Bit order
    logic [2:0]  res_code;        // Output resolution field
    logic [3:0]  lane_sel;        // Lanes that lane writes reach
    logic        patt_route;      // Send pattern instead of samples
    logic [7:0]  next_patt_lo;
    logic [7:0]  next_patt_hi;
    logic        next_lsb_first;
    logic        next_low_rate;
    logic [2:0]  next_res_code;
    logic [3:0]  next_lane_sel;
    logic        next_patt_route;
    logic [3:0]  next_lane_rst;
    logic [3:0]  next_lane_pd;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic [5:0]  idx;             // Word index of the access
    logic        aligned;         // Byte address on a word boundary
    logic        hit;             // Address maps to a register
    logic        setup;           // APB setup cycle
    logic        wr_take;         // Write commits this edge
    logic [7:0]  rd_byte;         // Read value of the addressed register
    logic [7:0]  lane_rd;         // Lane state of lowest selected lane
    logic [3:0]  nbits;           // Decoded serial word length
    logic [13:0] pat_word;        // Pattern two clipped to word width
    logic        load;            // Word boundary from the counter

    assign idx     = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup   = psel && !penable;
    assign wr_take = psel && penable && pready && pwrite;

    // Address map lookup
    always_comb begin
        hit = 1'b0;
        if (aligned) begin
            unique case (idx)
                `AOSCR_IDX_PATT_LO, `AOSCR_IDX_PATT_HI, `AOSCR_IDX_STREAM,
                `AOSCR_IDX_LANE, `AOSCR_IDX_LANE_SEL, `AOSCR_IDX_ROUTE: begin
                    hit = 1'b1;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Resolution decode
    // ****************************************************************
    always_comb begin
        // Any other code keeps the native word length
        unique case (res_code)
            AOSCR_RES_12: begin
                nbits = `AOSCR_NBITS_12; // R6
            end
            AOSCR_RES_14: begin
                nbits = `AOSCR_NBITS_14; // R6
            end
            default: begin
                nbits = `AOSCR_NBITS_NATIVE; // R4
            end
        endcase
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    // Lane read shows the lowest selected lane; none selected reads zero
    always_comb begin
        lane_rd = `AOSCR_RST_BYTE;
        for (int i = `AOSCR_NCH - 1; i >= 0; i--) begin
            if (lane_sel[i]) begin
                lane_rd = `AOSCR_RST_BYTE;
                lane_rd[`AOSCR_CH_RST_BIT] = lane_out_reset[i];
                lane_rd[`AOSCR_CH_PD_BIT]  = lane_power_down[i];
            end
        end
    end

    // Byte of the addressed register, reserved bits zero
    always_comb begin
        rd_byte = `AOSCR_RST_BYTE;
        unique case (idx)
            `AOSCR_IDX_PATT_LO: begin
                rd_byte = patt_lo;
            end
            `AOSCR_IDX_PATT_HI: begin
                rd_byte = patt_hi;
            end
            `AOSCR_IDX_STREAM: begin
                rd_byte[`AOSCR_LSB_FIRST_BIT] = lsb_first;
                rd_byte[`AOSCR_LOW_RATE_BIT]  = low_rate_mode;
                rd_byte[`AOSCR_RES_HI:`AOSCR_RES_LO] = res_code;
            end
            `AOSCR_IDX_LANE: begin
                rd_byte = lane_rd;
            end
            `AOSCR_IDX_LANE_SEL: begin
                rd_byte[3:0] = lane_sel;
            end
            `AOSCR_IDX_ROUTE: begin
                rd_byte[`AOSCR_ROUTE_BIT] = patt_route;
            end
            default: begin
                rd_byte = `AOSCR_RST_BYTE;
            end
        endcase
    end

    // ****************************************************************
    // Register next values
    // ****************************************************************
    always_comb begin
        next_patt_lo    = patt_lo;
        next_patt_hi    = patt_hi;
        next_lsb_first  = lsb_first;
        next_low_rate   = low_rate_mode;
        next_res_code   = res_code;
        next_lane_sel   = lane_sel;
        next_patt_route = patt_route;
        next_lane_rst   = lane_out_reset;
        next_lane_pd    = lane_power_down;
        // Answer one cycle after setup, so every access is two cycles
        next_pready     = setup;
        next_pslverr    = setup && !hit;
        next_prdata     = prdata;
        if (setup) begin
            next_prdata = (hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
        if (wr_take && hit) begin
            unique case (idx)
                `AOSCR_IDX_PATT_LO: begin
                    next_patt_lo = pwdata[7:0]; // R1
                end
                `AOSCR_IDX_PATT_HI: begin
                    next_patt_hi = pwdata[7:0]; // R2
                end
                `AOSCR_IDX_STREAM: begin
                    next_lsb_first = pwdata[`AOSCR_LSB_FIRST_BIT]; // R3
                    next_low_rate  = pwdata[`AOSCR_LOW_RATE_BIT]; // R5
                    next_res_code  = pwdata[`AOSCR_RES_HI:`AOSCR_RES_LO]; // R6
                end
                `AOSCR_IDX_LANE: begin
                    // Unselected lanes keep their state
                    for (int i = 0; i < `AOSCR_NCH; i++) begin
                        if (lane_sel[i]) begin
                            next_lane_rst[i] = pwdata[`AOSCR_CH_RST_BIT]; // R7 R9
                            next_lane_pd[i]  = pwdata[`AOSCR_CH_PD_BIT]; // R8 R9
                        end
                    end
                end
                `AOSCR_IDX_LANE_SEL: begin
                    next_lane_sel = pwdata[3:0];
                end
                `AOSCR_IDX_ROUTE: begin
                    next_patt_route = pwdata[`AOSCR_ROUTE_BIT];
                end
                default: begin
                    next_patt_lo = patt_lo;
                end
            endcase
        end
    end

    // Registers only; all formats clear to the default stream
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            patt_lo         <= `AOSCR_RST_BYTE; // R1
            patt_hi         <= `AOSCR_RST_BYTE; // R2
            lsb_first       <= 1'b0; // R4
            low_rate_mode   <= 1'b0; // R5
            res_code        <= 3'h0; // R4
            lane_sel        <= `AOSCR_RST_LANE_SEL;
            patt_route      <= 1'b0;
            lane_out_reset  <= 4'h0; // R7
            lane_power_down <= 4'h0; // R8
            prdata          <= 32'h00000000;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
        end else begin
            patt_lo         <= next_patt_lo;
            patt_hi         <= next_patt_hi;
            lsb_first       <= next_lsb_first;
            low_rate_mode   <= next_low_rate;
            res_code        <= next_res_code;
            lane_sel        <= next_lane_sel;
            patt_route      <= next_patt_route;
            lane_out_reset  <= next_lane_rst;
            lane_power_down <= next_lane_pd;
            prdata          <= next_prdata;
            pready          <= next_pready;
            pslverr         <= next_pslverr;
        end
    end

    // ****************************************************************
    // Frame counter and lanes
    // ****************************************************************
    assign pat_word = {patt_hi[5:0], patt_lo};

    aoscr_frame u_frame (
        .pclk    (pclk),
        .presetn (presetn),
        .nbits   (nbits),
        .load    (load),
        .frame   (frame_out)
    );

    aoscr_lane_if lane_bus [`AOSCR_NCH] ();

    // Stream format is global; hold is per lane
    for (genvar g = 0; g < `AOSCR_NCH; g++) begin : g_lane
        assign lane_bus[g].load      = load;
        assign lane_bus[g].word      = patt_route ? pat_word : sample_word[g];
        assign lane_bus[g].nbits     = nbits; // R4
        assign lane_bus[g].lsb_first = lsb_first; // R3
        assign lane_bus[g].hold      = lane_out_reset[g] | lane_power_down[g]; // R10
        assign serial_data[g]        = lane_bus[g].dout;
        aoscr_lane u_lane (
            .pclk    (pclk),
            .presetn (presetn),
            .lnk     (lane_bus[g])
        );
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Committed write to a given index
    sequence s_wr(logic [5:0] i);
        psel && penable && pready && pwrite && aligned && (idx == i);
    endsequence

    // Lane 0 starts a word while active
    sequence s_start0;
        load && !lane_bus[0].hold;
    endsequence

    chk_patt_low_write: assert property ( // R1
        s_wr(`AOSCR_IDX_PATT_LO) |=> (patt_lo == $past(pwdata[7:0])))
        else $error("pattern low byte not written");

    chk_patt_high_write: assert property ( // R2
        s_wr(`AOSCR_IDX_PATT_HI) |=> (patt_hi == $past(pwdata[7:0])))
        else $error("pattern high byte not written");

    chk_lsb_first_out: assert property ( // R3
        (s_start0 and lsb_first) |=> (serial_data[0] == $past(lane_bus[0].word[0])))
        else $error("lsb first word did not start at bit zero");

    chk_msb_first_out: assert property ( // R4
        (s_start0 and !lsb_first)
        |=> (serial_data[0] == $past(lane_bus[0].word[nbits - 4'h1])))
        else $error("msb first word did not start at top bit");

    chk_low_rate_bit: assert property ( // R5
        s_wr(`AOSCR_IDX_STREAM) |=> (low_rate_mode == $past(pwdata[`AOSCR_LOW_RATE_BIT])))
        else $error("low encode rate bit not written");

    chk_res_decode: assert property ( // R6
        (res_code == AOSCR_RES_12 |-> nbits == `AOSCR_NBITS_12)
        and (res_code == AOSCR_RES_14 |-> nbits == `AOSCR_NBITS_14)
        and ((res_code != AOSCR_RES_12 && res_code != AOSCR_RES_14)
             |-> nbits == `AOSCR_NBITS_NATIVE))
        else $error("resolution decode wrong");

    chk_frame_period: assert property ( // R6
        // Shortest word is ten bits, so eight quiet cycles always follow
        load |=> !load [*8])
        else $error("frame boundary repeated too soon");

    chk_lane_reset_apply: assert property ( // R7
        (s_wr(`AOSCR_IDX_LANE) and lane_sel[0])
        |=> (lane_out_reset[0] == $past(pwdata[`AOSCR_CH_RST_BIT])))
        else $error("lane output reset not applied");

    chk_lane_pd_apply: assert property ( // R8
        (s_wr(`AOSCR_IDX_LANE) and lane_sel[0])
        |=> (lane_power_down[0] == $past(pwdata[`AOSCR_CH_PD_BIT])))
        else $error("lane power down not applied");

    chk_lane_local: assert property ( // R9
        (s_wr(`AOSCR_IDX_LANE) and !lane_sel[1])
        |=> ($stable(lane_out_reset[1]) && $stable(lane_power_down[1])))
        else $error("unselected lane changed");

    chk_lane_quiet: assert property ( // R10
        lane_bus[0].hold [*2] |-> (serial_data[0] == 1'b0))
        else $error("held lane still sending");
endmodule
`default_nettype wire

// [verification/aoscr_rx_model.sv]
/*
 * Far-side receiver model: rebuilds each lane word from the serial bits.
 * Assumes frame_out marks the first bit of every word, one bit per pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module aoscr_rx_model (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             frame_out,
    input  wire logic [3:0]       serial_data,
    output logic      [3:0][13:0] word,
    output logic      [4:0]       len
);
    // ****************************************************************
    // Shift state
    // ****************************************************************
    logic [3:0][13:0] acc;  // Bits of the word in flight, arrival order
    logic [4:0]       cnt;  // Bits seen since the last frame mark

    // Latch a finished word at each frame mark; order is left to the bench
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc  <= '0;
            word <= '0;
            cnt  <= 5'h00;
            len  <= 5'h00;
        end else if (frame_out) begin
            for (int i = 0; i < 4; i++) begin
                acc[i] <= {13'h0000, serial_data[i]};
            end
            word <= acc;
            len  <= cnt;
            cnt  <= 5'h01;
        end else begin
            for (int i = 0; i < 4; i++) begin
                acc[i] <= {acc[i][12:0], serial_data[i]};
            end
            cnt <= cnt + 5'h01;
        end
    end
endmodule
`default_nettype wire

// [verification/tb.sv]
/*
 * Self-checking bench for the stream configuration bank: APB tasks,
 * register checks and lane word checks through the receiver model.
 * Assumes the design header and package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aoscr_consts.svh"
module tb;
    // ****************************************************************
    // Stimulus and observation
    // ****************************************************************
    logic             pclk, presetn, psel, penable, pwrite;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata;
    logic             pready, pslverr, frame_out, low_rate_mode;
    logic [3:0][13:0] sample_word, rx_word, exp_w;
    logic [3:0]       serial_data, lane_power_down, lane_out_reset;
    logic [4:0]       rx_len;
    logic [31:0]      rd;
    logic             err;
    int               bad_count, checked, cycles;
    logic [2:0]       codes [4] = '{3'h3, 3'h4, 3'h0, 3'h7};  // Resolution codes
    int               nbs   [4] = '{12, 14, 10, 10};          // Their word lengths

    aoscr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_word(sample_word),
        .serial_data(serial_data), .frame_out(frame_out), .low_rate_mode(low_rate_mode),
        .lane_power_down(lane_power_down), .lane_out_reset(lane_out_reset));
    aoscr_rx_model rx_u (.pclk(pclk), .presetn(presetn), .frame_out(frame_out),
        .serial_data(serial_data), .word(rx_word), .len(rx_len));

    // Clock of 25 ns
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; no wait count assumed, the timeout cuts a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register read with expected byte and no error
    task automatic rdx(input logic [5:0] idx, input logic [7:0] e);
        apb(1'b0, {idx, 2'b00}, 8'h00);
        // Data and error flag compared apart so neither hides the other
        chk(rd, {24'h000000, e});
        chk({31'h0, err}, 32'h0);
    endtask

    // Wait for three frame marks, then compare every lane word and length
    task automatic lanes(input int nb, input logic lsb, input logic [3:0] quiet);
        int f;
        f = 0;
        while (f < 3) begin
            @(posedge pclk);
            if (frame_out === 1'b1) f++;
        end
        @(negedge pclk);
        for (int i = 0; i < 4; i++) begin
            exp_w[i] = '0;
            for (int b = 0; b < nb; b++) begin
                exp_w[i][lsb ? nb - 1 - b : b] = quiet[i] ? 1'b0 : sample_word[i][b];
            end
            chk({18'h0, rx_word[i]}, {18'h0, exp_w[i]});
        end
        chk({27'h0, rx_len}, nb);
    endtask

    // ****************************************************************
    // Hang guard, generous against roughly 500 expected cycles
    // ****************************************************************
    always @(posedge pclk) begin
        cycles++;
        if (cycles >= 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        bad_count = 0;
        checked   = 0;
        cycles    = 0;
        presetn   = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        sample_word = {14'h2AAA, 14'h0F0F, 14'h1234, 14'h3A5C};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values
        rdx(`AOSCR_IDX_PATT_LO, 8'h00);
        rdx(`AOSCR_IDX_PATT_HI, 8'h00);
        rdx(`AOSCR_IDX_STREAM, 8'h00);
        rdx(`AOSCR_IDX_LANE, 8'h00);
        chk({low_rate_mode, lane_power_down, lane_out_reset}, 32'h0);
        // Misaligned and unmapped accesses are refused and leave data alone
        apb(1'b1, 8'h6D, 8'h77);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h00, 8'h00);
        chk({rd[30:0], err}, 32'h1);
        rdx(`AOSCR_IDX_PATT_LO, 8'h00);
        // Default: MSB first, native width, every lane
        lanes(10, 1'b0, 4'h0);
        // Pattern two readback and routing onto the lanes
        apb(1'b1, {`AOSCR_IDX_PATT_LO, 2'b00}, 8'hA5);
        apb(1'b1, {`AOSCR_IDX_PATT_HI, 2'b00}, 8'hFC);
        rdx(`AOSCR_IDX_PATT_LO, 8'hA5);
        rdx(`AOSCR_IDX_PATT_HI, 8'hFC);
        apb(1'b1, {`AOSCR_IDX_ROUTE, 2'b00}, 8'h01);
        sample_word <= {4{14'h3CA5}};
        lanes(10, 1'b0, 4'h0);
        // Resolution codes 3, 4, 0 and 7 in both bit orders
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, {`AOSCR_IDX_STREAM, 2'b00}, {k[0], 4'h0, codes[k / 2]});
            rdx(`AOSCR_IDX_STREAM, {k[0], 4'h0, codes[k / 2]});
            lanes(nbs[k / 2], k[0], 4'h0);
        end
        // Low encode rate mode bit
        apb(1'b1, {`AOSCR_IDX_STREAM, 2'b00}, 8'h08);
        @(posedge pclk);
        chk({31'h0, low_rate_mode}, 32'h1);
        lanes(10, 1'b0, 4'h0);
        // Lane reset on lane 1 only, power-down on lane 2 only
        apb(1'b1, {`AOSCR_IDX_LANE_SEL, 2'b00}, 8'h02);
        apb(1'b1, {`AOSCR_IDX_LANE, 2'b00}, 8'h02);
        apb(1'b1, {`AOSCR_IDX_LANE_SEL, 2'b00}, 8'h04);
        apb(1'b1, {`AOSCR_IDX_LANE, 2'b00}, 8'h01);
        @(posedge pclk);
        chk({28'h0, lane_out_reset}, 32'h2);
        chk({28'h0, lane_power_down}, 32'h4);
        rdx(`AOSCR_IDX_LANE, 8'h01);
        lanes(10, 1'b0, 4'h6);
        // Release both lanes together
        apb(1'b1, {`AOSCR_IDX_LANE_SEL, 2'b00}, 8'h06);
        apb(1'b1, {`AOSCR_IDX_LANE, 2'b00}, 8'h00);
        @(posedge pclk);
        chk({24'h0, lane_out_reset, lane_power_down}, 32'h0);
        lanes(10, 1'b0, 4'h0);
        // Mid-run reset returns written registers to their defaults
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rdx(`AOSCR_IDX_PATT_HI, 8'h00);
        rdx(`AOSCR_IDX_STREAM, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
